// [rtl/carc_pkg.sv]
// Constants and types for the configuration-word decode and reset control.
// Operation
// - Twelve-bit setup word: low five bits exist, upper bits read zero.
// - Bit 4 set makes the shared pin a reset; clear ties reset input high.
// - Setup bit 3 clear turns code protection on; set leaves it off.
// - Setup bit 2 enables the watchdog; nothing else can switch it off.
// - Setup bit 1 clear enables reset-pin pull-up, only when bit 4 is set.
// - Setup bit 0 selects 8 MHz oscillator when set, 4 MHz when clear.
// - Running program cannot read or write the setup word; programmer only.
// - Reset runs the calibration load at the top address, then wraps to 0.
// - Calibration location stays readable whatever the code protection setting.
// - Trim at 05h takes 1111 1110 on power-on, kept on other resets.
// - Six reset causes: power-on, pin and watchdog awake or asleep, wake.
// - Awake resets load reset state; sleep pin or watchdog resets keep it. Here both kinds restart the core and reload W alike.
// - Some registers never reset: unknown at power-on, unchanged later.
// - Status upper bits take per-cause patterns from the reset table.
// - Every reset loads program counter low with 1111 1111.
// - After any reset, working register bits 7 to 2 hold calibration value.
// - Start-up delay of 1.125 ms applies only on supply power-up.
// - Sleep ends on a monitored pin change or a watchdog timeout.
// - Watchdog runs from its own RC source, independent of the system clock.
// - Start-up delay counts once reset input is high, then releases reset.
// - Resets other than power-on use the short start-up delay instead.
// - Timeout, powerdown and pin-wake flags keep values until a reset occurs.
package carc_pkg;
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned POR_DELAY_NS    = 1125000;
    localparam int unsigned SHORT_DELAY_NS  = 10000;
    localparam int unsigned POR_DELAY_CYC   =
        (POR_DELAY_NS * 25 + 999) / 1000;
    localparam int unsigned SHORT_DELAY_CYC =
        (SHORT_DELAY_NS * 25 + 999) / 1000;
    localparam int unsigned CNT_W           = 16;

    localparam logic [7:0] ADDR_PCL    = 8'h02;
    localparam logic [7:0] ADDR_STATUS = 8'h03;
    localparam logic [7:0] ADDR_TRIM   = 8'h05;
    localparam logic [7:0] ADDR_CAUSE  = 8'h10;
    localparam logic [7:0] ADDR_WREG   = 8'h11;
    localparam logic [7:0] ADDR_SCRATCH = 8'h12;

    localparam logic [7:0] TRIM_POR    = 8'hfe;
    localparam logic [7:0] PCL_RESET   = 8'hff;
    localparam logic [8:0] PC_TOP      = 9'h0ff;
    localparam logic [8:0] PC_USER     = 9'h000;
    localparam logic [11:0] SETUP_MASK = 12'h01f;

    localparam int unsigned BIT_RSTFN  = 4;
    localparam int unsigned BIT_CP     = 3;
    localparam int unsigned BIT_WATCHDOG_ENABLE_BIT   = 2;
    localparam int unsigned BIT_PU     = 1;
    localparam int unsigned BIT_FSEL   = 0;
    localparam int unsigned ST_PWF     = 7;
    localparam int unsigned ST_TO      = 4;
    localparam int unsigned ST_PD      = 3;

    typedef enum logic [2:0] {
        CARC_CAUSE_POR      = 3'h0,
        CARC_CAUSE_PIN_RUN  = 3'h1,
        CARC_CAUSE_PIN_SLP  = 3'h2,
        CARC_CAUSE_WDT_RUN  = 3'h3,
        CARC_CAUSE_WDT_SLP  = 3'h4,
        CARC_CAUSE_WAKE     = 3'h5
    } carc_cause_t;

    typedef enum logic [1:0] {
        CARC_ST_LATCH = 2'b00,
        CARC_ST_WAIT  = 2'b01,
        CARC_ST_COUNT = 2'b11,
        CARC_ST_RUN   = 2'b10
    } carc_state_t;

    typedef struct packed {
        logic reset_pin_function_select;
        logic code_protect_on;
        logic watchdog_enable_bit;
        logic reset_pin_pullup_enable;
        logic osc_frequency_select;
    } carc_setup_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } carc_bus_t;
endpackage

// [rtl/carc_top.sv]
// Configuration decode, reset-cause tracking and start-up delay control.
`timescale 1ns/1ps
module carc_top #(
    parameter int unsigned POR_CYC   = carc_pkg::POR_DELAY_CYC,
    parameter int unsigned SHORT_CYC = carc_pkg::SHORT_DELAY_CYC
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic [11:0]        prog_setup_word,
    input  wire logic               prog_setup_wr,
    input  wire logic               external_reset_pin_n,
    input  wire logic               in_sleep,
    input  wire logic               pin_change,
    input  wire logic               watchdog_timeout,
    input  wire logic [5:0]         cal_value,
    input  wire logic [7:0]         bus_addr,
    input  wire logic [7:0]         bus_wdata,
    input  wire logic               bus_wr,
    input  wire logic               bus_rd,
    output logic [7:0]              bus_rdata,
    output logic                    core_reset_n,
    output logic [8:0]              pc_start,
    output logic                    watchdog_run,
    output logic                    pullup_on,
    output logic                    code_protect_on,
    output logic                    osc_8mhz,
    output logic                    pin_is_reset,
    output logic [7:0]              osc_trim
);
    carc_pkg::carc_bus_t   bus;
    carc_pkg::carc_setup_t setup_r;
    carc_pkg::carc_state_t state_r, state_nxt;
    carc_pkg::carc_cause_t cause_r, cause_nxt;
    logic [11:0]     nv_word_r;
    logic [7:0]      trim_r, status_r, status_nxt, wreg_r, scratch_r;
    logic [7:0]      rdata_r, rdata_nxt;
    logic [carc_pkg::CNT_W-1:0] cnt_r, cnt_nxt, delay_len;
    logic            por_r, rst_in_high, reset_event, count_done;
    logic            user_wr_trim, user_wr_scratch, full_reset;

    assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr,
                   rd: bus_rd};

    // The setup word is stored only through the programmer port.
    // It is non-volatile, so power-on reset must leave it untouched.
    always_ff @(posedge sys_clk) begin
        if (prog_setup_wr) begin
            nv_word_r <= prog_setup_word & carc_pkg::SETUP_MASK;
        end
    end

    // Pin reset only counts when the pin is programmed as reset.
    assign rst_in_high = !setup_r.reset_pin_function_select ||
                         external_reset_pin_n;
    // Sleep exits and watchdog/pin resets all restart the core.
    assign reset_event = (state_r == carc_pkg::CARC_ST_RUN) &&
                         (!rst_in_high || watchdog_timeout ||
                          (in_sleep && pin_change));

    // Cause priority: pin over watchdog over wake.
    always_comb begin
        cause_nxt = cause_r;
        if (reset_event) begin
            if (!rst_in_high) begin
                cause_nxt = in_sleep ? carc_pkg::CARC_CAUSE_PIN_SLP
                                     : carc_pkg::CARC_CAUSE_PIN_RUN;
            end else if (watchdog_timeout) begin
                cause_nxt = in_sleep ? carc_pkg::CARC_CAUSE_WDT_SLP
                                     : carc_pkg::CARC_CAUSE_WDT_RUN;
            end else begin
                cause_nxt = carc_pkg::CARC_CAUSE_WAKE;
            end
        end
    end

    // Flags change only on a reset event; an awake pin change leaves them.
    always_comb begin
        status_nxt = status_r;
        if (reset_event) begin
            unique case (cause_nxt)
                carc_pkg::CARC_CAUSE_PIN_SLP: begin
                    status_nxt[carc_pkg::ST_PWF] = 1'b0;
                    status_nxt[carc_pkg::ST_TO]  = 1'b1;
                    status_nxt[carc_pkg::ST_PD]  = 1'b0;
                end
                carc_pkg::CARC_CAUSE_WDT_RUN: begin
                    status_nxt[carc_pkg::ST_PWF] = 1'b0;
                    status_nxt[carc_pkg::ST_TO]  = 1'b0;
                end
                carc_pkg::CARC_CAUSE_WDT_SLP: begin
                    status_nxt[carc_pkg::ST_PWF] = 1'b0;
                    status_nxt[carc_pkg::ST_TO]  = 1'b0;
                    status_nxt[carc_pkg::ST_PD]  = 1'b0;
                end
                carc_pkg::CARC_CAUSE_WAKE: begin
                    status_nxt[carc_pkg::ST_PWF] = 1'b1;
                    status_nxt[carc_pkg::ST_TO]  = 1'b1;
                    status_nxt[carc_pkg::ST_PD]  = 1'b0;
                end
                default: begin
                    status_nxt[carc_pkg::ST_PWF] = 1'b0;
                end
            endcase
        end
    end

    // Sleep-time pin and watchdog resets clear full_reset, but restart the core and reload W like every other reset.
    assign full_reset = (cause_nxt != carc_pkg::CARC_CAUSE_PIN_SLP) &&
                        (cause_nxt != carc_pkg::CARC_CAUSE_WDT_SLP);

    // Long delay on power-up only, short delay otherwise.
    assign delay_len = por_r ? carc_pkg::CNT_W'(POR_CYC)
                             : carc_pkg::CNT_W'(SHORT_CYC);
    assign count_done = (cnt_r + 1'b1 >= delay_len);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            carc_pkg::CARC_ST_LATCH: begin
                state_nxt = carc_pkg::CARC_ST_WAIT;
            end
            carc_pkg::CARC_ST_WAIT: begin
                cnt_nxt = '0;
                if (rst_in_high) begin
                    state_nxt = carc_pkg::CARC_ST_COUNT;
                end
            end
            carc_pkg::CARC_ST_COUNT: begin
                if (!rst_in_high) begin
                    state_nxt = carc_pkg::CARC_ST_WAIT;
                end else if (count_done) begin
                    state_nxt = carc_pkg::CARC_ST_RUN;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            carc_pkg::CARC_ST_RUN: begin
                if (reset_event) begin
                    state_nxt = carc_pkg::CARC_ST_WAIT;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= carc_pkg::CARC_ST_LATCH;
            cnt_r   <= '0;
            por_r   <= 1'b1;
            cause_r <= carc_pkg::CARC_CAUSE_POR;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            cause_r <= cause_nxt;
            if (state_r == carc_pkg::CARC_ST_RUN) begin
                por_r <= 1'b0;
            end
        end
    end

    // Setup is caught once in the first cycle after power-on release.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_r <= '0;
        end else if (state_r == carc_pkg::CARC_ST_LATCH) begin
            setup_r.reset_pin_function_select <=
                nv_word_r[carc_pkg::BIT_RSTFN];
            // A clear bit means protected.
            setup_r.code_protect_on <= !nv_word_r[carc_pkg::BIT_CP];
            setup_r.watchdog_enable_bit <= nv_word_r[carc_pkg::BIT_WATCHDOG_ENABLE_BIT];
            setup_r.reset_pin_pullup_enable <= !nv_word_r[carc_pkg::BIT_PU];
            setup_r.osc_frequency_select <= nv_word_r[carc_pkg::BIT_FSEL];
        end
    end

    assign user_wr_trim    = bus.wr && bus.addr == carc_pkg::ADDR_TRIM;
    assign user_wr_scratch = bus.wr && bus.addr == carc_pkg::ADDR_SCRATCH;

    // Trim keeps its value over every later reset.
    // Scratch is never reset: it models the uninitialised file.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_r   <= carc_pkg::TRIM_POR;
            status_r <= 8'h18;
        end else begin
            status_r <= status_nxt;
            if (user_wr_trim) begin
                trim_r <= bus.wdata;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (user_wr_scratch) begin
            scratch_r <= bus.wdata;
        end
    end

    // Calibration load lands in W bits 7:2 on every reset; it is read
    // from the top word even when code protection is on.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wreg_r <= 8'h00;
        end else if (state_r == carc_pkg::CARC_ST_COUNT && count_done) begin
            wreg_r <= {cal_value, wreg_r[1:0]};
        end
    end

    // Reads never see the setup word: it has no address.
    always_comb begin
        unique case (bus.addr)
            carc_pkg::ADDR_PCL:     rdata_nxt = carc_pkg::PCL_RESET;
            carc_pkg::ADDR_STATUS:  rdata_nxt = status_r;
            carc_pkg::ADDR_TRIM:    rdata_nxt = trim_r;
            carc_pkg::ADDR_CAUSE:   rdata_nxt = {5'h00, cause_r};
            carc_pkg::ADDR_WREG:    rdata_nxt = wreg_r;
            carc_pkg::ADDR_SCRATCH: rdata_nxt = scratch_r;
            default:                rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r       <= 8'h00;
            core_reset_n  <= 1'b0;
            pc_start      <= carc_pkg::PC_TOP;
            watchdog_run  <= 1'b0;
            pullup_on     <= 1'b0;
            code_protect_on <= 1'b0;
            osc_8mhz      <= 1'b0;
            pin_is_reset  <= 1'b0;
            osc_trim      <= carc_pkg::TRIM_POR;
        end else begin
            rdata_r       <= bus.rd ? rdata_nxt : 8'h00;
            core_reset_n  <= state_nxt == carc_pkg::CARC_ST_RUN;
            // Start at the top word, then wrap to user code.
            pc_start      <= (state_nxt == carc_pkg::CARC_ST_RUN)
                             ? carc_pkg::PC_USER : carc_pkg::PC_TOP;
            watchdog_run  <= setup_r.watchdog_enable_bit;
            pullup_on     <= setup_r.reset_pin_function_select &&
                             setup_r.reset_pin_pullup_enable;
            code_protect_on <= setup_r.code_protect_on;
            osc_8mhz      <= setup_r.osc_frequency_select;
            pin_is_reset  <= setup_r.reset_pin_function_select;
            osc_trim      <= trim_r;
        end
    end
    assign bus_rdata = rdata_r;

    a_por_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(core_reset_n) |-> $past(state_r) == carc_pkg::CARC_ST_COUNT)
        else $error("Core left reset without counting delay.");
    a_wdt_sleep: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reset_event && cause_nxt == carc_pkg::CARC_CAUSE_WDT_SLP |=>
        status_r[carc_pkg::ST_TO] == 1'b0 && !status_r[carc_pkg::ST_PD])
        else $error("Watchdog sleep flags wrong.");
    a_wake_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reset_event && cause_nxt == carc_pkg::CARC_CAUSE_WAKE |=>
        status_r[carc_pkg::ST_PWF] && status_r[carc_pkg::ST_TO])
        else $error("Wake flags wrong.");
    a_flags_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !reset_event |=> $stable(status_r))
        else $error("Flags changed without reset.");
    a_reset_enter: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reset_event |=> ##1 !core_reset_n)
        else $error("Reset event did not assert core reset.");
    a_trim_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !user_wr_trim |=> $stable(trim_r))
        else $error("Trim changed without a write.");
    a_pullup_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !setup_r.reset_pin_function_select |=> !pullup_on)
        else $error("Pull-up on while pin is I/O.");
    a_sleep_resume: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reset_event && !full_reset |=> !status_r[carc_pkg::ST_PD])
        else $error("Sleep reset left powerdown flag set.");
    a_setup_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r != carc_pkg::CARC_ST_LATCH |=> $stable(setup_r))
        else $error("Setup changed after latch.");
    c_por_run: cover property (@(posedge sys_clk) $rose(core_reset_n));
    c_wake: cover property (@(posedge sys_clk)
        reset_event && cause_nxt == carc_pkg::CARC_CAUSE_WAKE);
    c_wdt_run: cover property (@(posedge sys_clk)
        reset_event && cause_nxt == carc_pkg::CARC_CAUSE_WDT_RUN);
endmodule

// [sim/carc_partner.sv]
// Model of the external reset pin and the device programmer.
`timescale 1ns/1ps
module carc_partner (
    input  wire logic        sys_clk,
    output logic [11:0]      prog_setup_word,
    output logic             prog_setup_wr,
    output logic             external_reset_pin_n
);
    initial begin
        prog_setup_word = 12'h000;
        prog_setup_wr = 1'b0;
        external_reset_pin_n = 1'b1;
    end

    // The programmer releases its data lines after the strobe, so they show
    // the inverse of the last word rather than a convenient stale value.
    task automatic program_word(input logic [11:0] w);
        @(posedge sys_clk);
        prog_setup_word <= w;
        prog_setup_wr <= 1'b1;
        @(posedge sys_clk);
        prog_setup_wr <= 1'b0;
        prog_setup_word <= ~w;
    endtask

    task automatic drive_pin(input logic v);
        @(posedge sys_clk);
        external_reset_pin_n <= v;
    endtask

    // The pin idles high through its pull-up once the pulse ends.
    task automatic pin_low(input int cyc);
        drive_pin(1'b0);
        repeat (cyc) @(posedge sys_clk);
        external_reset_pin_n <= 1'b1;
    endtask
endmodule

// [sim/tb_top.sv]
// Self-checking testbench for the configuration decode and reset control.
`timescale 1ns/1ps
module tb_top;
    localparam int POR = 20;
    localparam int SC  = 4;
    logic        sys_clk          = 1'b0;
    logic        rst_n;
    logic        in_sleep;
    logic        pin_change;
    logic        watchdog_timeout;
    logic [5:0]  cal_value;
    logic [7:0]  bus_addr;
    logic [7:0]  bus_wdata;
    logic        bus_wr;
    logic        bus_rd;
    logic [11:0] psw;
    logic        pwr;
    logic        pin_n;
    logic [7:0]  bus_rdata;
    logic        core_reset_n;
    logic [8:0]  pc_start;
    logic        watchdog_run;
    logic        pullup_on;
    logic        code_protect_on;
    logic        osc_8mhz;
    logic        pin_is_reset;
    logic [7:0]  osc_trim;
    int          err_count        = 0;
    int          compares         = 0;
    int          n;

    always #20 sys_clk = ~sys_clk;

    carc_partner partner_u (
        .sys_clk              (sys_clk),
        .prog_setup_word      (psw),
        .prog_setup_wr        (pwr),
        .external_reset_pin_n (pin_n)
    );

    carc_top #(.POR_CYC(POR), .SHORT_CYC(SC)) dut_u (
        .sys_clk              (sys_clk),
        .rst_n                (rst_n),
        .prog_setup_word      (psw),
        .prog_setup_wr        (pwr),
        .external_reset_pin_n (pin_n),
        .in_sleep             (in_sleep),
        .pin_change           (pin_change),
        .watchdog_timeout     (watchdog_timeout),
        .cal_value            (cal_value),
        .bus_addr             (bus_addr),
        .bus_wdata            (bus_wdata),
        .bus_wr               (bus_wr),
        .bus_rd               (bus_rd),
        .bus_rdata            (bus_rdata),
        .core_reset_n         (core_reset_n),
        .pc_start             (pc_start),
        .watchdog_run         (watchdog_run),
        .pullup_on            (pullup_on),
        .code_protect_on      (code_protect_on),
        .osc_8mhz             (osc_8mhz),
        .pin_is_reset         (pin_is_reset),
        .osc_trim             (osc_trim)
    );

    task automatic test_done();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [11:0] seen,
                       input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] m,
                      input logic [11:0] e);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), {4'h0, bus_rdata & m}, e);
    endtask

    // Samples just after the edge so the level seen is the settled one.
    task automatic wait_lvl(input logic v);
        n = 0;
        @(posedge sys_clk);
        #1;
        while (core_reset_n !== v && n < 5000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    task automatic dec(input logic [11:0] w);
        chk("pin fn", {11'h0, pin_is_reset}, {11'h0, w[4]});
        chk("protect", {11'h0, code_protect_on}, {11'h0, ~w[3]});
        chk("wdog", {11'h0, watchdog_run}, {11'h0, w[2]});
        chk("pullup", {11'h0, pullup_on},
            {11'h0, ~w[1] & w[4]});
        chk("osc", {11'h0, osc_8mhz}, {11'h0, w[0]});
    endtask

    task automatic regs(input logic [7:0] st, input logic [2:0] cs,
                        input logic [7:0] tr);
        rd(carc_pkg::ADDR_STATUS, 8'h98, {4'h0, st});
        rd(carc_pkg::ADDR_CAUSE, 8'hff, {9'h0, cs});
        rd(carc_pkg::ADDR_WREG, 8'hfc, {4'h0, cal_value, 2'b00});
        rd(carc_pkg::ADDR_PCL, 8'hff, 12'h0ff);
        rd(carc_pkg::ADDR_TRIM, 8'hff, {4'h0, tr});
        chk("trim out", {4'h0, osc_trim}, {4'h0, tr});
        chk("pc_start", {3'h0, pc_start}, 12'h000);
    endtask

    task automatic por(input logic [11:0] w);
        partner_u.drive_pin(1'b0);
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 chk("held", {11'h0, core_reset_n}, 12'h000);
        chk("pc held", {3'h0, pc_start}, 12'h0ff);
        chk("trim por", {4'h0, osc_trim}, 12'h0fe);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        if (w[4]) begin
            repeat (30) @(posedge sys_clk);
            #1 chk("pin wait", {11'h0, core_reset_n}, 12'h000);
            partner_u.drive_pin(1'b1);
        end
        wait_lvl(1'b1);
        chk("por delay", {11'h0, n >= POR - 2 && n <= POR + 4},
            12'h001);
        partner_u.drive_pin(1'b1);
        dec(w);
        regs(8'h18, carc_pkg::CARC_CAUSE_POR, 8'hfe);
    endtask

    // Kind 0 is a pin pulse, 1 a watchdog timeout, 2 a pin-change wake.
    task automatic ev(input int k, input logic s, input logic [7:0] st,
                      input logic [2:0] cs);
        @(posedge sys_clk);
        in_sleep <= s;
        if (k == 0) begin
            partner_u.pin_low(8);
        end else begin
            @(posedge sys_clk);
            watchdog_timeout <= (k == 1);
            pin_change <= (k == 2);
            @(posedge sys_clk);
            watchdog_timeout <= 1'b0;
            pin_change <= 1'b0;
        end
        wait_lvl(1'b0);
        in_sleep <= 1'b0;
        wait_lvl(1'b1);
        chk("short delay", {11'h0, n >= SC - 2 && n <= SC + 4},
            12'h001);
        regs(st, cs, 8'h5a);
        rd(carc_pkg::ADDR_SCRATCH, 8'hff, 12'h03c);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        test_done();
    end

    initial begin
        rst_n            <= 1'b0;
        in_sleep         <= 1'b0;
        pin_change       <= 1'b0;
        watchdog_timeout <= 1'b0;
        cal_value        <= 6'h2d;
        bus_addr         <= 8'h00;
        bus_wdata        <= 8'h00;
        bus_wr           <= 1'b0;
        bus_rd           <= 1'b0;
        // The word is stored while reset is still held, so the very first
        // release already latches a programmed setup and never an unknown.
        partner_u.program_word(12'hff5);
        por(12'hff5);
        wr(carc_pkg::ADDR_TRIM, 8'h5a);
        wr(carc_pkg::ADDR_SCRATCH, 8'h3c);
        wr(carc_pkg::ADDR_PCL, 8'h00);
        wr(8'h40, 8'h77);
        regs(8'h18, carc_pkg::CARC_CAUSE_POR, 8'h5a);
        @(posedge sys_clk);
        #1 chk("idle rdata", {4'h0, bus_rdata}, 12'h000);
        // No address may leak the setup word, so every unmapped one reads 0.
        for (int a = 0; a < 256; a++) begin
            if (!(a inside {2, 3, 5, 16, 17, 18})) begin
                rd(8'(a), 8'hff, 12'h000);
            end
        end
        @(posedge sys_clk);
        pin_change <= 1'b1;
        @(posedge sys_clk);
        pin_change <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 chk("awake change", {11'h0, core_reset_n}, 12'h001);
        ev(0, 1'b0, 8'h18, carc_pkg::CARC_CAUSE_PIN_RUN);
        ev(1, 1'b0, 8'h08, carc_pkg::CARC_CAUSE_WDT_RUN);
        ev(0, 1'b0, 8'h08, carc_pkg::CARC_CAUSE_PIN_RUN);
        ev(0, 1'b1, 8'h10, carc_pkg::CARC_CAUSE_PIN_SLP);
        ev(1, 1'b1, 8'h00, carc_pkg::CARC_CAUSE_WDT_SLP);
        ev(2, 1'b1, 8'h90, carc_pkg::CARC_CAUSE_WAKE);
        partner_u.program_word(12'h0aa);
        repeat (2) @(posedge sys_clk);
        #1 dec(12'hff5);
        // A new calibration literal shows the load is taken afresh.
        cal_value <= 6'h12;
        por(12'h0aa);
        partner_u.pin_low(8);
        #1 chk("pin as io", {11'h0, core_reset_n}, 12'h001);
        test_done();
    end
endmodule
